// ==== rtl/rsm_regs.sv ====
// regulator status, power-good flags and top event mask register bank
// =====================================================
// Contract
// [R1] switcher status bit7: switcher one enabled
// [R2] switcher status bit3: switcher zero enabled
// [R3] switcher status bit6: switcher one vout invalid
// [R4] switcher status bit2: switcher zero vout invalid
// [R5] switcher status bit4: switcher one current limit
// [R6] switcher status bit0: switcher zero current limit
// [R7] linear status bit7: linear one enabled
// [R8] linear status bit3: linear zero enabled
// [R9] linear status bit6: linear one vout invalid
// [R10] linear status bit2: linear zero vout invalid
// [R11] linear status bit4: linear one current limit
// [R12] linear status bit0: linear zero current limit
// [R13] mask bit7 set suppresses power-good interrupt
// [R14] mask never alters power-good pin status
// [R15] power-good status follows output pin
// [R16] power-good events latch flags, write-one clears
// [R17] status writes ignored, reserved bits zero
// [R18] variant mask bits load from factory store
module rsm_regs
	import rsm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic sw1_enabled,
	input wire logic sw0_enabled,
	input wire logic sw1_vout_invalid,
	input wire logic sw0_vout_invalid,
	input wire logic sw1_curlimit_active,
	input wire logic sw0_curlimit_active,
	input wire logic lin1_enabled,
	input wire logic lin0_enabled,
	input wire logic lin1_vout_invalid,
	input wire logic lin0_vout_invalid,
	input wire logic lin1_curlimit_active,
	input wire logic lin0_curlimit_active,
	input wire logic power_good_out,
	input wire logic [7:0] factoryMask,
	output logic power_good_pin_state,
	output logic power_good_irq_flag,
	output logic power_good_irq_mask
);
	// =====================================================
	// status capture
	logic [7:0] swStatus;
	logic [7:0] linStatus;
	logic [7:0] next_swStatus;
	logic [7:0] next_linStatus;
	logic next_pinState;

	always_comb
	begin
		next_swStatus = STATUS_RESET;
		next_linStatus = STATUS_RESET;
		// reserved bits 5 and 1 stay zero
		next_swStatus[CH1_ENABLED_BIT] = sw1_enabled; // R1
		next_swStatus[CH0_ENABLED_BIT] = sw0_enabled; // R2
		next_swStatus[CH1_VOUT_BIT] = sw1_vout_invalid; // R3
		next_swStatus[CH0_VOUT_BIT] = sw0_vout_invalid; // R4
		next_swStatus[CH1_CURLIM_BIT] = sw1_curlimit_active; // R5
		next_swStatus[CH0_CURLIM_BIT] = sw0_curlimit_active; // R6
		next_linStatus[CH1_ENABLED_BIT] = lin1_enabled; // R7
		next_linStatus[CH0_ENABLED_BIT] = lin0_enabled; // R8
		next_linStatus[CH1_VOUT_BIT] = lin1_vout_invalid; // R9
		next_linStatus[CH0_VOUT_BIT] = lin0_vout_invalid; // R10
		next_linStatus[CH1_CURLIM_BIT] = lin1_curlimit_active; // R11
		next_linStatus[CH0_CURLIM_BIT] = lin0_curlimit_active; // R12
		// pin state ignores the mask entirely
		next_pinState = power_good_out; // R14 R15
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			swStatus <= STATUS_RESET;
			linStatus <= STATUS_RESET;
			power_good_pin_state <= 1'b0;
		end
		else
		begin
			swStatus <= next_swStatus;
			linStatus <= next_linStatus;
			power_good_pin_state <= next_pinState;
		end
	end

	// =====================================================
	// mask register with factory load after reset
	logic [7:0] topMask;
	logic [7:0] next_topMask;
	logic maskLoaded;
	logic next_maskLoaded;
	logic maskWrite;

	assign maskWrite = regWrEn && regAddr == TOP_MASK_ADDR;

	always_comb
	begin
		next_topMask = topMask;
		next_maskLoaded = 1'b1;
		// strap caught on first clock after release, not under reset
		if (!maskLoaded)
			next_topMask = factoryMask & MASK_WRITABLE; // R18
		else if (maskWrite)
			next_topMask = regWrData & MASK_WRITABLE;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			topMask <= MASK_RESET;
			maskLoaded <= 1'b0;
		end
		else
		begin
			topMask <= next_topMask;
			maskLoaded <= next_maskLoaded;
		end
	end

	// =====================================================
	// latched power-good event flags
	logic [7:0] swFlags;
	logic [7:0] linFlags;
	logic [7:0] next_swFlags;
	logic [7:0] next_linFlags;
	logic [7:0] swEvt;
	logic [7:0] linEvt;
	logic pgEvt;
	logic pgPrev;
	logic next_irqFlag;

	always_comb
	begin
		swEvt = 8'h00;
		linEvt = 8'h00;
		// any change of validity counts as an event
		swEvt[FLAG_VOUT1_BIT] = next_swStatus[CH1_VOUT_BIT]
			^ swStatus[CH1_VOUT_BIT];
		swEvt[FLAG_VOUT0_BIT] = next_swStatus[CH0_VOUT_BIT]
			^ swStatus[CH0_VOUT_BIT];
		linEvt[FLAG_VOUT1_BIT] = next_linStatus[CH1_VOUT_BIT]
			^ linStatus[CH1_VOUT_BIT];
		linEvt[FLAG_VOUT0_BIT] = next_linStatus[CH0_VOUT_BIT]
			^ linStatus[CH0_VOUT_BIT];
		next_swFlags = swFlags;
		next_linFlags = linFlags;
		if (regWrEn && regAddr == SW_FLAG_ADDR)
			next_swFlags = swFlags & ~regWrData;
		if (regWrEn && regAddr == LIN_FLAG_ADDR)
			next_linFlags = linFlags & ~regWrData;
		// set after clear, so a same-cycle event wins
		next_swFlags = next_swFlags | swEvt; // R16
		next_linFlags = next_linFlags | linEvt; // R16
		pgEvt = power_good_out ^ pgPrev;
		next_irqFlag = pgEvt && !topMask[PG_MASK_BIT]; // R13
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			swFlags <= FLAG_RESET;
			linFlags <= FLAG_RESET;
			pgPrev <= 1'b0;
			power_good_irq_flag <= 1'b0;
			power_good_irq_mask <= 1'b0;
		end
		else
		begin
			swFlags <= next_swFlags;
			linFlags <= next_linFlags;
			pgPrev <= power_good_out;
			power_good_irq_flag <= next_irqFlag;
			power_good_irq_mask <= next_topMask[PG_MASK_BIT];
		end
	end

	// =====================================================
	// read port; writes to status offsets fall through
	logic [7:0] next_rdData;

	always_comb
	begin
		next_rdData = regRdData;
		if (regRdEn)
		begin
			unique case (regAddr)
				SW_STATUS_ADDR: next_rdData = swStatus; // R17
				LIN_STATUS_ADDR: next_rdData = linStatus; // R17
				TOP_MASK_ADDR: next_rdData = topMask;
				SW_FLAG_ADDR: next_rdData = swFlags;
				LIN_FLAG_ADDR: next_rdData = linFlags;
				default: next_rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= 8'h00;
		else
			regRdData <= next_rdData;
	end

	// =====================================================
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_sw1_enable_track: assert property ( // R1
		##1 swStatus[CH1_ENABLED_BIT] == $past(sw1_enabled))
		else $error("sw1 enable status wrong");
	a_sw0_enable_track: assert property ( // R2
		sw0_enabled |=> swStatus[CH0_ENABLED_BIT])
		else $error("sw0 enable status wrong");
	a_sw1_vout_track: assert property ( // R3
		$rose(sw1_vout_invalid) |=> swStatus[CH1_VOUT_BIT])
		else $error("sw1 vout status wrong");
	a_sw0_vout_track: assert property ( // R4
		!sw0_vout_invalid |=> !swStatus[CH0_VOUT_BIT])
		else $error("sw0 vout status wrong");
	a_sw1_curlim_track: assert property ( // R5
		sw1_curlimit_active[*2] |-> swStatus[CH1_CURLIM_BIT])
		else $error("sw1 limit status wrong");
	a_sw0_curlim_track: assert property ( // R6
		sw0_curlimit_active |=> swStatus[CH0_CURLIM_BIT])
		else $error("sw0 limit status wrong");
	a_lin1_enable_track: assert property ( // R7
		lin1_enabled |=> linStatus[CH1_ENABLED_BIT])
		else $error("lin1 enable status wrong");
	a_lin0_enable_track: assert property ( // R8
		!lin0_enabled |=> !linStatus[CH0_ENABLED_BIT])
		else $error("lin0 enable status wrong");
	a_lin1_vout_track: assert property ( // R9
		lin1_vout_invalid |=> linStatus[CH1_VOUT_BIT])
		else $error("lin1 vout status wrong");
	a_lin0_vout_track: assert property ( // R10
		lin0_vout_invalid |=> linStatus[CH0_VOUT_BIT])
		else $error("lin0 vout status wrong");
	a_lin1_curlim_track: assert property ( // R11
		lin1_curlimit_active |=> linStatus[CH1_CURLIM_BIT])
		else $error("lin1 limit status wrong");
	a_lin0_curlim_track: assert property ( // R12
		lin0_curlimit_active |=> linStatus[CH0_CURLIM_BIT])
		else $error("lin0 limit status wrong");
	a_pg_irq_masked: assert property ( // R13
		topMask[PG_MASK_BIT] |=> !power_good_irq_flag)
		else $error("masked power-good interrupt raised");
	a_pg_irq_raise: assert property ( // R13
		!topMask[PG_MASK_BIT] && (power_good_out ^ pgPrev)
		|=> power_good_irq_flag)
		else $error("unmasked power-good interrupt missing");
	a_irq_mask_copy: assert property ( // R13
		power_good_irq_mask == topMask[PG_MASK_BIT])
		else $error("mask output differs from register");
	a_mask_write: assert property ( // R13
		maskWrite && maskLoaded
		|=> topMask == ($past(regWrData) & MASK_WRITABLE))
		else $error("mask write not taken");
	a_pg_pin_follow: assert property ( // R14 R15
		power_good_out |=> power_good_pin_state)
		else $error("power-good pin state wrong");
	a_flag_sticky: assert property ( // R16
		swFlags[FLAG_VOUT1_BIT] && !(regWrEn && regAddr == SW_FLAG_ADDR)
		|=> swFlags[FLAG_VOUT1_BIT])
		else $error("power-good flag lost");
	a_flag_set_wins: assert property ( // R16
		swEvt[FLAG_VOUT1_BIT] |=> swFlags[FLAG_VOUT1_BIT])
		else $error("switcher flag not set");
	a_lin_flag_set: assert property ( // R16
		linEvt[FLAG_VOUT0_BIT] |=> linFlags[FLAG_VOUT0_BIT])
		else $error("linear flag not set");
	a_flag_clear: assert property ( // R16
		swFlags[FLAG_VOUT0_BIT] && regWrEn && regAddr == SW_FLAG_ADDR
		&& regWrData[FLAG_VOUT0_BIT] && !swEvt[FLAG_VOUT0_BIT]
		|=> !swFlags[FLAG_VOUT0_BIT])
		else $error("switcher flag not cleared");
	a_status_reserved: assert property ( // R17
		swStatus[5] == 1'b0 && linStatus[1] == 1'b0)
		else $error("reserved status bit set");
	a_lin_reserved: assert property ( // R17
		linStatus[5] == 1'b0 && swStatus[1] == 1'b0)
		else $error("reserved status bit high");
	a_status_wr_ignored: assert property ( // R17
		regWrEn && regAddr == SW_STATUS_ADDR
		|=> swStatus == $past(next_swStatus))
		else $error("status write took effect");
	a_rd_status_data: assert property ( // R17
		regRdEn && regAddr == LIN_STATUS_ADDR |=> regRdData == $past(linStatus))
		else $error("linear status read wrong");
	a_mask_factory: assert property ( // R18
		$rose(maskLoaded) |-> topMask == ($past(factoryMask)
		& MASK_WRITABLE))
		else $error("factory mask not loaded");

	c_pg_event: cover property ($rose(power_good_irq_flag));
	c_flag_clear: cover property ($fell(swFlags[FLAG_VOUT1_BIT]));
	c_mask_write: cover property (maskWrite);
	c_status_read: cover property (regRdEn && regAddr == SW_STATUS_ADDR);
	c_masked_edge: cover property (topMask[PG_MASK_BIT] && (power_good_out ^ pgPrev));
endmodule

// ==== rtl/rsm_pkg.sv ====
// package for the regulator status and mask register bank
package rsm_pkg;
	// =====================================================
	// register offsets
	localparam logic [7:0] SW_STATUS_ADDR = 8'h1e;
	localparam logic [7:0] LIN_STATUS_ADDR = 8'h1f;
	localparam logic [7:0] TOP_MASK_ADDR = 8'h20;
	// =====================================================
	// field positions, shared by both status registers, plus PG_MASK_BIT in the top mask
	localparam int CH1_ENABLED_BIT = 7;
	localparam int CH1_VOUT_BIT = 6;
	localparam int CH1_CURLIM_BIT = 4;
	localparam int CH0_ENABLED_BIT = 3;
	localparam int CH0_VOUT_BIT = 2;
	localparam int CH0_CURLIM_BIT = 0;
	localparam int PG_MASK_BIT = 7;
	// =====================================================
	// reset values, writable bits, flag offsets and flag bit positions
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_WRITABLE = 8'h95;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] SW_FLAG_ADDR = 8'h1b;
	localparam logic [7:0] LIN_FLAG_ADDR = 8'h1c;
	localparam int FLAG_VOUT1_BIT = 6;
	localparam int FLAG_VOUT0_BIT = 2;
endpackage

// ==== tb/rsm_host.sv ====
// host model driving the register port of the status and mask bank
module rsm_host
(
	input wire logic ref_clk,
	input wire logic [7:0] regRdData,
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	// =====================================================
	// bus cycles
	// idle address shows the inverse after both cycles, idle data only after a write, so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		@(posedge ref_clk);
		#1;
		d = regRdData;
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the status and mask register bank
module testbench
	import rsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic rst_n;
	logic power_good_out;
	logic [11:0] mon;
	logic [7:0] factoryMask;
	logic regWrEn, regRdEn;
	logic [7:0] regAddr, regWrData, regRdData, d, pulses;
	logic power_good_pin_state, power_good_irq_flag, power_good_irq_mask;
	int seed = 32'h013995d9;
	int n_mismatch = 0;
	int samples_checked = 0;
	rsm_host i_host (.ref_clk(ref_clk), .regRdData(regRdData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData));
	rsm_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .sw1_enabled(mon[11]),
		.sw1_vout_invalid(mon[10]), .sw1_curlimit_active(mon[9]),
		.sw0_enabled(mon[8]), .sw0_vout_invalid(mon[7]),
		.sw0_curlimit_active(mon[6]), .lin1_enabled(mon[5]),
		.lin1_vout_invalid(mon[4]), .lin1_curlimit_active(mon[3]),
		.lin0_enabled(mon[2]), .lin0_vout_invalid(mon[1]),
		.lin0_curlimit_active(mon[0]), .power_good_out(power_good_out),
		.factoryMask(factoryMask), .power_good_pin_state(power_good_pin_state),
		.power_good_irq_flag(power_good_irq_flag),
		.power_good_irq_mask(power_good_irq_mask));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// =====================================================
	// expectations and comparisons
	// m is {en1, vout1, lim1, en0, vout0, lim0}; bits 5 and 1 read zero
	function automatic logic [7:0] exp_stat(input logic [5:0] m);
		exp_stat = {m[5], m[4], 1'b0, m[3], m[2], m[1], 1'b0, m[0]};
	endfunction
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// =====================================================
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		mon = 12'h000;
		power_good_out = 1'b0;
		factoryMask = 8'($random(seed));
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		i_host.rd(TOP_MASK_ADDR, d);
		check8(d, factoryMask & MASK_WRITABLE);
		i_host.rd(8'h55, d);
		check8(d, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 20; i++)
		begin
			@(posedge ref_clk);
			mon <= (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($random(seed));
			i_host.wr(i[0] ? SW_STATUS_ADDR : LIN_STATUS_ADDR, 8'($random(seed)));
			i_host.rd(SW_STATUS_ADDR, d);
			check8(d, exp_stat(mon[11:6]));
			i_host.rd(LIN_STATUS_ADDR, d);
			check8(d, exp_stat(mon[5:0]));
		end
		$display("test status done");
		for (int k = 0; k < 2; k++)
		begin
			i_host.wr(TOP_MASK_ADDR, k ? 8'h00 : 8'hff);
			i_host.rd(TOP_MASK_ADDR, d);
			check8(d, k ? 8'h00 : MASK_WRITABLE);
			check1(power_good_irq_mask, k == 0);
			@(posedge ref_clk);
			power_good_out <= ~power_good_out;
			pulses = 8'h00;
			// pulse latency is short; four cycles cover it
			repeat (4)
			begin
				@(posedge ref_clk);
				#1;
				pulses = pulses + {7'h00, power_good_irq_flag};
			end
			check1(power_good_pin_state, power_good_out);
			check8(pulses, k ? 8'h01 : 8'h00);
		end
		$display("test power good done");
		for (int k = 0; k < 2; k++)
			i_host.wr(k ? LIN_FLAG_ADDR : SW_FLAG_ADDR, 8'hff);
		@(posedge ref_clk);
		mon <= mon ^ 12'h402;
		@(posedge ref_clk);
		mon <= mon ^ 12'h402;
		// monitors are back to their old level: only a latch keeps the flag
		for (int k = 0; k < 2; k++)
		begin
			i_host.rd(k ? LIN_FLAG_ADDR : SW_FLAG_ADDR, d);
			check8(d, k ? 8'h04 : 8'h40);
			i_host.wr(k ? LIN_FLAG_ADDR : SW_FLAG_ADDR, 8'hff);
			i_host.rd(k ? LIN_FLAG_ADDR : SW_FLAG_ADDR, d);
			check8(d, 8'h00);
		end
		$display("test flags done");
		close_out();
	end
endmodule
